// File: rtl/front_end_trim_registers.sv
// front-end trim register bank with decode into analog control lines
//
// Functional notes
// - trim bits 1:0 pick feedback resistor 200k/100k/50k, reset code 0
// - trim bits 3:2 pick band-pass poles, reset code 2
// - trim bits 5:4 pick reference 13,12,15,14 sixteenths, reset code 0
// - trim bits 12:8 integrator select, reset 0x1C: cap high, resistor low
// - capacitor equals 3.62pF*b12 + 1.81pF*b11 + 0.9pF*b10
// - bits 9:8: 00 gives 200k, 01 gives 100k, else 50k
// - path word resets 0xADA5 full path; 0xB065 routes amplifier to converter
// - led bits 11:7 reset 0xC, led scale (21.25+0.3125*v)/25
`timescale 1ns/1ps
module front_end_trim_registers
  import fe_trim_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire logic [fe_trim_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                          reg_wr_en,
  input  wire logic [fe_trim_pkg::DATA_W-1:0] reg_wr_data,
  input  wire logic                          reg_rd_en,
  output logic      [fe_trim_pkg::DATA_W-1:0] reg_rd_data,
  output logic                               reg_rd_valid,
  output logic                               reg_addr_hit,
  output logic      [2:0]                    tia_gain_select,
  output logic      [3:0]                    bandpass_pole_select,
  output logic      [3:0]                    amp_reference_select,
  output logic      [4:0]                    integrator_select,
  output logic      [2:0]                    integrator_cap_enable,
  output logic      [12:0]                   integrator_capacitor,
  output logic      [2:0]                    integrator_res_select,
  output logic                               full_path_en,
  output logic                               tia_direct_en,
  output logic      [4:0]                    led_current_scale,
  output logic      [8:0]                    led_scale_sixteenths
);
  import fe_trim_pkg::*;

  trim_words_if words ();

  trim_register_bank u_bank (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .clk_en       (clk_en),
    .reg_addr     (reg_addr),
    .reg_wr_en    (reg_wr_en),
    .reg_wr_data  (reg_wr_data),
    .reg_rd_en    (reg_rd_en),
    .reg_rd_data  (reg_rd_data),
    .reg_rd_valid (reg_rd_valid),
    .reg_addr_hit (reg_addr_hit),
    .words        (words.bank)
  );

  // one-hot select of three analog legs, lowest leg for code 0
  function automatic logic [2:0] three_way(input logic [1:0] code);
    logic [2:0] leg;
    leg = 3'b100;
    if (code == 2'b00) begin
      leg = 3'b001;
    end else if (code == 2'b01) begin
      leg = 3'b010;
    end
    return leg;
  endfunction

  function automatic logic [3:0] vref_numerator(input logic [1:0] code);
    logic [3:0] num;
    num = VREF_CODE3;
    unique case (code)
      2'd0: num = VREF_CODE0;
      2'd1: num = VREF_CODE1;
      2'd2: num = VREF_CODE2;
      2'd3: num = VREF_CODE3;
    endcase
    return num;
  endfunction

  wire [1:0]  tia_code  = words.trim[TIA_LSB +: 2];
  wire [1:0]  bpf_code  = words.trim[BPF_LSB +: 2];
  wire [1:0]  vref_code = words.trim[VREF_LSB +: 2];
  wire [1:0]  res_code  = words.trim[RES_LSB +: 2];
  wire [2:0]  cap_bits  = words.trim[CAP_LSB +: 3];
  wire [4:0]  led_code  = words.led[LED_LSB +: LED_W];

  // code 3 of the gain field is undefined; it falls to the 50k leg
  wire [2:0]  tia_nxt   = three_way(tia_code);
  wire [3:0]  bpf_nxt   = 4'(4'b0001 << bpf_code);
  wire [3:0]  vref_nxt  = vref_numerator(vref_code);
  wire [2:0]  res_nxt   = three_way(res_code);
  wire [12:0] cap_nxt   = (cap_bits[2] ? CAP_BIT12_FF : 13'd0)
                        + (cap_bits[1] ? CAP_BIT11_FF : 13'd0)
                        + (cap_bits[0] ? CAP_BIT10_FF : 13'd0);
  wire        full_nxt  = (words.path == PATH_FULL);
  wire        direct_nxt = (words.path == PATH_TIA);
  wire [8:0]  led_nxt   = LED_BASE_16 + 9'(LED_STEP_16 * {4'h0, led_code});

  logic [2:0]  tia_r;
  logic [3:0]  bpf_r;
  logic [3:0]  vref_r;
  logic [4:0]  int_r;
  logic [2:0]  capen_r;
  logic [12:0] cap_r;
  logic [2:0]  res_r;
  logic        full_r;
  logic        direct_r;
  logic [4:0]  ledc_r;
  logic [8:0]  leds_r;

  // registered so analog switches never see decode glitches
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tia_r    <= 3'b001;
      bpf_r    <= 4'b0100;
      vref_r   <= VREF_CODE0;
      int_r    <= RST_TRIM[INT_LSB +: INT_W];
      capen_r  <= 3'b111;
      cap_r    <= CAP_BIT12_FF + CAP_BIT11_FF + CAP_BIT10_FF;
      res_r    <= 3'b001;
      full_r   <= 1'b1;
      direct_r <= 1'b0;
      ledc_r   <= RST_LED[LED_LSB +: LED_W];
      leds_r   <= 9'd400;
    end else if (clk_en) begin
      tia_r    <= tia_nxt;
      bpf_r    <= bpf_nxt;
      vref_r   <= vref_nxt;
      int_r    <= words.trim[INT_LSB +: INT_W];
      capen_r  <= cap_bits;
      cap_r    <= cap_nxt;
      res_r    <= res_nxt;
      full_r   <= full_nxt;
      direct_r <= direct_nxt;
      ledc_r   <= led_code;
      leds_r   <= led_nxt;
    end
  end

  assign tia_gain_select       = tia_r;
  assign bandpass_pole_select  = bpf_r;
  assign amp_reference_select  = vref_r;
  assign integrator_select     = int_r;
  assign integrator_cap_enable = capen_r;
  assign integrator_capacitor  = cap_r;
  assign integrator_res_select = res_r;
  assign full_path_en          = full_r;
  assign tia_direct_en         = direct_r;
  assign led_current_scale     = ledc_r;
  assign led_scale_sixteenths  = leds_r;

  property p_tia;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[1:0] == 2'd1) |=> (tia_gain_select == 3'b010);
  endproperty
  a_tia: assert property (p_tia) else $error("gain code 1 not 100k");

  property p_bpf;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[3:2] == 2'd3) |=> (bandpass_pole_select == 4'b1000);
  endproperty
  a_bpf: assert property (p_bpf) else $error("pole code 3 wrong");

  property p_vref;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[5:4] == 2'd2) |=> (amp_reference_select == 4'd15);
  endproperty
  a_vref: assert property (p_vref) else $error("reference code 2 not 15/16");

  property p_reset_trim;
    @(posedge ref_clk) reset |=> (words.trim == 16'h1C08 && words.led == 16'h0600);
  endproperty
  a_reset_trim: assert property (p_reset_trim) else $error("trim reset wrong");

  property p_cap;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[12:10] == 3'b101) |=> (integrator_capacitor == 13'd4520);
  endproperty
  a_cap: assert property (p_cap) else $error("capacitor sum wrong");

  property p_res;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[9:8] == 2'b11) |=> (integrator_res_select == 3'b100);
  endproperty
  a_res: assert property (p_res) else $error("resistor code 3 not 50k");

  property p_path;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.path == 16'hB065) |=> (tia_direct_en && !full_path_en);
  endproperty
  a_path: assert property (p_path) else $error("direct path not selected");

  property p_led;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.led[11:7] == 5'd31) |=> (led_scale_sixteenths == 9'd495);
  endproperty
  a_led: assert property (p_led) else $error("led scale wrong");

  property p_tia_zero;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[1:0] == 2'd0) |=> (tia_gain_select == 3'b001);
  endproperty
  a_tia_zero: assert property (p_tia_zero) else $error("gain code 0 not 200k");

  property p_tia_two;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[1:0] == 2'd2) |=> (tia_gain_select == 3'b100);
  endproperty
  a_tia_two: assert property (p_tia_two) else $error("gain code 2 not 50k");

  property p_bpf_zero;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[3:2] == 2'd0) |=> (bandpass_pole_select == 4'b0001);
  endproperty
  a_bpf_zero: assert property (p_bpf_zero) else $error("pole code 0 wrong");

  property p_bpf_one;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[3:2] == 2'd1) |=> (bandpass_pole_select == 4'b0010);
  endproperty
  a_bpf_one: assert property (p_bpf_one) else $error("pole code 1 wrong");

  property p_bpf_two;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[3:2] == 2'd2) |=> (bandpass_pole_select == 4'b0100);
  endproperty
  a_bpf_two: assert property (p_bpf_two) else $error("pole code 2 wrong");

  property p_vref_zero;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[5:4] == 2'd0) |=> (amp_reference_select == 4'd13);
  endproperty
  a_vref_zero: assert property (p_vref_zero) else $error("reference code 0 wrong");

  property p_vref_one;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[5:4] == 2'd1) |=> (amp_reference_select == 4'd12);
  endproperty
  a_vref_one: assert property (p_vref_one) else $error("reference code 1 wrong");

  property p_vref_three;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[5:4] == 2'd3) |=> (amp_reference_select == 4'd14);
  endproperty
  a_vref_three: assert property (p_vref_three) else $error("reference code 3 wrong");

  property p_int_copy;
    @(posedge ref_clk) disable iff (reset)
      clk_en |=> (integrator_select == $past(words.trim[12:8]));
  endproperty
  a_int_copy: assert property (p_int_copy) else $error("integrator field lost");

  property p_capen_copy;
    @(posedge ref_clk) disable iff (reset)
      clk_en |=> (integrator_cap_enable == $past(words.trim[12:10]));
  endproperty
  a_capen_copy: assert property (p_capen_copy) else $error("capacitor bits lost");

  property p_cap_full;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[12:10] == 3'b111) |=> (integrator_capacitor == 13'd6330);
  endproperty
  a_cap_full: assert property (p_cap_full) else $error("full capacitor sum wrong");

  property p_cap_mid;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[12:10] == 3'b010) |=> (integrator_capacitor == 13'd1810);
  endproperty
  a_cap_mid: assert property (p_cap_mid) else $error("middle capacitor wrong");

  property p_res_zero;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[9:8] == 2'b00) |=> (integrator_res_select == 3'b001);
  endproperty
  a_res_zero: assert property (p_res_zero) else $error("resistor code 0 not 200k");

  property p_res_one;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[9:8] == 2'b01) |=> (integrator_res_select == 3'b010);
  endproperty
  a_res_one: assert property (p_res_one) else $error("resistor code 1 not 100k");

  property p_res_two;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.trim[9:8] == 2'b10) |=> (integrator_res_select == 3'b100);
  endproperty
  a_res_two: assert property (p_res_two) else $error("resistor code 2 not 50k");

  property p_path_full;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.path == 16'hADA5) |=> (full_path_en && !tia_direct_en);
  endproperty
  a_path_full: assert property (p_path_full) else $error("full path not selected");

  property p_path_other;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.path != 16'hADA5 && words.path != 16'hB065)
        |=> (!full_path_en && !tia_direct_en);
  endproperty
  a_path_other: assert property (p_path_other) else $error("unknown path word decoded");

  property p_led_zero;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && words.led[11:7] == 5'd0) |=> (led_scale_sixteenths == 9'd340);
  endproperty
  a_led_zero: assert property (p_led_zero) else $error("led base scale wrong");

  property p_led_copy;
    @(posedge ref_clk) disable iff (reset)
      clk_en |=> (led_current_scale == $past(words.led[11:7]));
  endproperty
  a_led_copy: assert property (p_led_copy) else $error("led field lost");

endmodule

// File: rtl/fe_trim_pkg.sv
// constants for the analog front-end trim register bank
package fe_trim_pkg;

  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned REG_COUNT = 6;

  // register indices inside the bank
  localparam int unsigned IDX_CONV_A = 0;
  localparam int unsigned IDX_CONV_B = 1;
  localparam int unsigned IDX_TRIM   = 2;
  localparam int unsigned IDX_PATH   = 3;
  localparam int unsigned IDX_BIAS_A = 4;
  localparam int unsigned IDX_LED    = 5;

  // register offsets
  localparam logic [7:0] OFF_CONV_A = 8'h10;
  localparam logic [7:0] OFF_CONV_B = 8'h11;
  localparam logic [7:0] OFF_TRIM   = 8'h12;
  localparam logic [7:0] OFF_PATH   = 8'h13;
  localparam logic [7:0] OFF_BIAS_A = 8'h14;
  localparam logic [7:0] OFF_LED    = 8'h16;

  // reset values
  localparam logic [15:0] RST_CONV_A = 16'h1010;
  localparam logic [15:0] RST_CONV_B = 16'h004C;
  localparam logic [15:0] RST_TRIM   = 16'h1C08;
  localparam logic [15:0] RST_PATH   = 16'hADA5;
  localparam logic [15:0] RST_BIAS_A = 16'h0080;
  localparam logic [15:0] RST_LED    = 16'h0600;

  // bits that exist; the trim word has no storage at 7:6 and 15
  localparam logic [15:0] MASK_FULL = 16'hFFFF;
  localparam logic [15:0] MASK_TRIM = 16'h7F3F;

  localparam logic [7:0]  REG_OFFSET [REG_COUNT] =
    '{OFF_CONV_A, OFF_CONV_B, OFF_TRIM, OFF_PATH, OFF_BIAS_A, OFF_LED};
  localparam logic [15:0] REG_RESET [REG_COUNT] =
    '{RST_CONV_A, RST_CONV_B, RST_TRIM, RST_PATH, RST_BIAS_A, RST_LED};
  localparam logic [15:0] REG_MASK [REG_COUNT] =
    '{MASK_FULL, MASK_FULL, MASK_TRIM, MASK_FULL, MASK_FULL, MASK_FULL};

  // field positions in the trim word
  localparam int unsigned TIA_LSB  = 0;
  localparam int unsigned BPF_LSB  = 2;
  localparam int unsigned VREF_LSB = 4;
  localparam int unsigned RES_LSB  = 8;
  localparam int unsigned CAP_LSB  = 10;
  localparam int unsigned INT_LSB  = 8;
  localparam int unsigned INT_W    = 5;
  // field position in the led word
  localparam int unsigned LED_LSB  = 7;
  localparam int unsigned LED_W    = 5;

  // path-select words
  localparam logic [15:0] PATH_FULL = 16'hADA5;
  localparam logic [15:0] PATH_TIA  = 16'hB065;

  // integrator capacitor weights in femtofarads
  localparam logic [12:0] CAP_BIT12_FF = 13'd3620;
  localparam logic [12:0] CAP_BIT11_FF = 13'd1810;
  localparam logic [12:0] CAP_BIT10_FF = 13'd900;

  // led scale numerator in sixteenths: 21.25 -> 340, 0.3125 -> 5
  localparam logic [8:0] LED_BASE_16 = 9'd340;
  localparam logic [8:0] LED_STEP_16 = 9'd5;

  // amp reference numerators in sixteenths of the core supply
  localparam logic [3:0] VREF_CODE0 = 4'd13;
  localparam logic [3:0] VREF_CODE1 = 4'd12;
  localparam logic [3:0] VREF_CODE2 = 4'd15;
  localparam logic [3:0] VREF_CODE3 = 4'd14;

endpackage

// File: rtl/trim_words_if.sv
// register words carried from the bank to the decode logic
`timescale 1ns/1ps
interface trim_words_if;
  logic [15:0] trim;
  logic [15:0] path;
  logic [15:0] led;
  modport bank (output trim, output path, output led);
  modport user (input trim, input path, input led);
endinterface

// File: rtl/trim_register_bank.sv
// storage and read path of the trim register bank
`timescale 1ns/1ps
module trim_register_bank
  import fe_trim_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire logic [fe_trim_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                          reg_wr_en,
  input  wire logic [fe_trim_pkg::DATA_W-1:0] reg_wr_data,
  input  wire logic                          reg_rd_en,
  output logic      [fe_trim_pkg::DATA_W-1:0] reg_rd_data,
  output logic                               reg_rd_valid,
  output logic                               reg_addr_hit,
  trim_words_if.bank                         words
);
  import fe_trim_pkg::*;

  logic [15:0]          bank_r [REG_COUNT];
  logic [REG_COUNT-1:0] sel;
  logic [15:0]          rd_nxt;
  logic [15:0]          rd_data_r;
  logic                 rd_valid_r;

  genvar i;
  generate
    for (i = 0; i < REG_COUNT; i++) begin : g_reg
      assign sel[i] = (reg_addr == REG_OFFSET[i]);
      // unmapped words are not stored; reserved trim bits are written as zero; reset loads defaults
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          bank_r[i] <= REG_RESET[i];
        end else if (clk_en && reg_wr_en && sel[i]) begin
          bank_r[i] <= reg_wr_data & REG_MASK[i];
        end
      end
    end
  endgenerate

  assign reg_addr_hit = |sel;

  // unmapped addresses read as zero
  always_comb begin
    rd_nxt = 16'h0000;
    for (int k = 0; k < REG_COUNT; k++) begin
      if (sel[k]) begin
        rd_nxt = rd_nxt | bank_r[k];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else if (clk_en) begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        rd_data_r <= rd_nxt;
      end
    end
  end

  assign reg_rd_data  = rd_data_r;
  assign reg_rd_valid = rd_valid_r;
  assign words.trim   = bank_r[IDX_TRIM];
  assign words.path   = bank_r[IDX_PATH];
  assign words.led    = bank_r[IDX_LED];

  property p_rd_valid;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && reg_rd_en && !reg_addr_hit) |=> (reg_rd_valid && reg_rd_data == 16'h0000);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("unmapped read not zero");

  property p_path_write;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && reg_wr_en && reg_addr == OFF_PATH) |=> (words.path == $past(reg_wr_data));
  endproperty
  a_path_write: assert property (p_path_write) else $error("path write lost");

endmodule

// File: tb/host_model.sv
// host-side register access driver for the trim bank
`timescale 1ns/1ps
module host_model (
  input  wire logic                           ref_clk,
  output logic      [fe_trim_pkg::ADDR_W-1:0] reg_addr,
  output logic                                reg_wr_en,
  output logic      [fe_trim_pkg::DATA_W-1:0] reg_wr_data,
  output logic                                reg_rd_en
);
  initial begin
    reg_addr    <= 8'h00;
    reg_wr_en   <= 1'b0;
    reg_wr_data <= 16'h0000;
    reg_rd_en   <= 1'b0;
  end
  // a strobe lasts one edge and is followed by an idle edge
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en   <= 1'b0;
    // stale data is inverted so it is never mistaken for a hold
    reg_wr_data <= ~d;
  endtask
  task automatic read(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
  endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the front-end trim register bank
`timescale 1ns/1ps
module tb_top;
  import fe_trim_pkg::*;
  logic        ref_clk;
  logic        reset;
  logic        clk_en;
  logic [7:0]  reg_addr;
  logic        reg_wr_en;
  logic [15:0] reg_wr_data;
  logic        reg_rd_en;
  logic [15:0] reg_rd_data;
  logic        reg_rd_valid;
  logic        reg_addr_hit;
  logic [2:0]  tia_gain_select;
  logic [3:0]  bandpass_pole_select;
  logic [3:0]  amp_reference_select;
  logic [4:0]  integrator_select;
  logic [2:0]  integrator_cap_enable;
  logic [12:0] integrator_capacitor;
  logic [2:0]  integrator_res_select;
  logic        full_path_en;
  logic        tia_direct_en;
  logic [4:0]  led_current_scale;
  logic [8:0]  led_scale_sixteenths;
  logic [15:0] q [$];
  logic [15:0] v;
  int          bad_count;
  int          check_count;
  logic [3:0]  vt [4] = '{4'd13, 4'd12, 4'd15, 4'd14};

  host_model host_model_inst (.ref_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en);
  front_end_trim_registers front_end_trim_registers_inst (.ref_clk, .reset, .clk_en,
    .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid,
    .reg_addr_hit, .tia_gain_select, .bandpass_pole_select, .amp_reference_select,
    .integrator_select, .integrator_cap_enable, .integrator_capacitor,
    .integrator_res_select, .full_path_en, .tia_direct_en, .led_current_scale,
    .led_scale_sixteenths);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // codes 2 and 3 both land on the third leg
  function automatic logic [2:0] hot3(input logic [1:0] c);
    return (c == 2'd0) ? 3'b001 : (c == 2'd1) ? 3'b010 : 3'b100;
  endfunction
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    q.push_back(exp);
    host_model_inst.read(a);
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_trim(input logic [15:0] t);
    check("tia", 16'(tia_gain_select), 16'(hot3(t[1:0])));
    check("bpf", 16'(bandpass_pole_select), 16'(4'b0001 << t[3:2]));
    check("vref", 16'(amp_reference_select), 16'(vt[t[5:4]]));
    check("int", 16'(integrator_select), 16'(t[12:8]));
    check("capen", 16'(integrator_cap_enable), 16'(t[12:10]));
    check("cap", 16'(integrator_capacitor), (t[12] ? 16'd3620 : 16'd0)
      + (t[11] ? 16'd1810 : 16'd0) + (t[10] ? 16'd900 : 16'd0));
    check("res", 16'(integrator_res_select), 16'(hot3(t[9:8])));
  endtask
  task automatic chk_path(input logic [15:0] p);
    check("full", 16'(full_path_en), 16'(p == 16'hADA5));
    check("direct", 16'(tia_direct_en), 16'(p == 16'hB065));
  endtask
  task automatic chk_led(input logic [15:0] l);
    check("ledc", 16'(led_current_scale), 16'(l[11:7]));
    check("leds", 16'(led_scale_sixteenths), 16'd340 + 16'd5 * l[11:7]);
  endtask
  task automatic chk_reset();
    logic [7:0]  offs [7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h15};
    logic [15:0] vals [7] = '{16'h1010, 16'h004C, 16'h1C08, 16'hADA5, 16'h0080,
                              16'h0600, 16'h0000};
    for (int k = 0; k < 7; k++) begin
      rd(offs[k], vals[k]);
      #1 check("hit", 16'(reg_addr_hit), 16'(k < 6));
    end
    settle();
    chk_trim(16'h1C08);
    chk_path(16'hADA5);
    chk_led(16'h0600);
  endtask
  task automatic drain();
    for (int k = 0; k < 20 && q.size() != 0; k++) @(posedge ref_clk);
    if (q.size() != 0) begin
      bad_count++;
      conclude();
    end
  endtask

  always @(posedge ref_clk) begin
    if (reg_rd_valid === 1'b1) begin
      if (q.size() == 0) check("rd_extra", 16'h0001, 16'h0000);
      else check("rd_data", reg_rd_data, q.pop_front());
    end
  end

  initial begin
    void'($urandom(32'h85500CCE));
    bad_count   = 0;
    check_count = 0;
    reset       <= 1'b1;
    clk_en      <= 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    chk_reset();
    for (int i = 0; i < 16; i++) begin
      // reserved trim bits kept at zero
      // first half walks every capacitor and resistor code, second half is random
      v = {3'b000, ((i < 8) ? {3'(i), 2'(i)} : 5'($urandom())),
           2'b00, 2'(i >> 2), 2'(i), 2'(i % 3)};
      host_model_inst.write(8'h12, v);
      rd(8'h12, v);
      settle();
      chk_trim(v);
    end
    foreach (vt[i]) begin
      v = (i == 0) ? 16'hB065 : (i == 3) ? 16'hADA5 : 16'($urandom());
      host_model_inst.write(8'h13, v);
      rd(8'h13, v);
      settle();
      chk_path(v);
    end
    for (int i = 0; i < 32; i++) begin
      v = {4'h0, 5'(i), 7'h00};
      host_model_inst.write(8'h16, v);
      settle();
      chk_led(v);
    end
    host_model_inst.write(8'h15, 16'($urandom()));
    rd(8'h15, 16'h0000);
    // a write while the clock enable is low must leave the word alone
    @(posedge ref_clk);
    clk_en <= 1'b0;
    host_model_inst.write(8'h16, 16'h0080);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(8'h16, 16'h0F80);
    drain();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    chk_reset();
    drain();
    conclude();
  end
endmodule
